// ==== disp_addr_ptr.sv ====
// Column and page pointers with range registers and wrapping
`timescale 1ns/1ps
`include "disp_cmd_map.svh"
module disp_addr_ptr #(
    parameter int COL_W = 7,
    parameter int PAGE_W = 3
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Control from the command decoder
    input wire disp_cmd_pkg::addr_mode_t mode_i,
    input wire logic advance_i,
    input wire logic [7:0] arg_i,
    input wire logic set_col_start_i,
    input wire logic set_col_end_i,
    input wire logic set_page_start_i,
    input wire logic set_page_end_i,
    input wire logic set_col_lo_i,
    input wire logic set_col_hi_i,
    input wire logic set_page_sel_i,
    // Pointers
    output logic [COL_W-1:0] col_ptr_o,
    output logic [PAGE_W-1:0] page_ptr_o
);
    import disp_cmd_pkg::*;

    typedef struct packed {
        logic [COL_W-1:0] col_ptr;
        logic [PAGE_W-1:0] page_ptr;
        logic [COL_W-1:0] col_start;
        logic [COL_W-1:0] col_end;
        logic [PAGE_W-1:0] page_start;
        logic [PAGE_W-1:0] page_end;
        logic [7:0] page_col_start;
    } ptr_state_t;

    localparam ptr_state_t RST = '{
        col_ptr: '0,
        page_ptr: '0,
        col_start: COL_W'(`RST_COL_START),
        col_end: COL_W'(`RST_COL_END),
        page_start: PAGE_W'(`RST_PAGE_START),
        page_end: PAGE_W'(`RST_PAGE_END),
        page_col_start: 8'h00
    };

    ptr_state_t s;
    ptr_state_t next_s;
    logic col_at_end;
    logic page_at_end;

    assign col_at_end = (s.col_ptr == s.col_end);
    assign page_at_end = (s.page_ptr == s.page_end);

    // Range loads, nibble loads and pointer stepping
    always_comb
    begin
        next_s = s;
        if (set_col_start_i)
        begin
            next_s.col_start = arg_i[COL_W-1:0];
            next_s.col_ptr = arg_i[COL_W-1:0];
        end
        if (set_col_end_i)
            next_s.col_end = arg_i[COL_W-1:0];
        if (set_page_start_i)
        begin
            next_s.page_start = arg_i[PAGE_W-1:0];
            next_s.page_ptr = arg_i[PAGE_W-1:0];
        end
        if (set_page_end_i)
            next_s.page_end = arg_i[PAGE_W-1:0];
        if (set_col_lo_i)
        begin
            next_s.page_col_start[3:0] = arg_i[3:0];
            next_s.col_ptr = COL_W'({s.page_col_start[7:4], arg_i[3:0]});
        end
        if (set_col_hi_i)
        begin
            next_s.page_col_start[7:4] = arg_i[3:0];
            next_s.col_ptr = COL_W'({arg_i[3:0], s.page_col_start[3:0]});
        end
        if (set_page_sel_i)
            next_s.page_ptr = arg_i[PAGE_W-1:0];
        if (advance_i)
        begin
            unique case (mode_i)
                MODE_PAGE:
                    next_s.col_ptr = col_at_end ? s.col_start
                        : COL_W'(s.col_ptr + 1'b1);
                MODE_HORIZ:
                begin
                    next_s.col_ptr = col_at_end ? s.col_start
                        : COL_W'(s.col_ptr + 1'b1);
                    if (col_at_end)
                        next_s.page_ptr = page_at_end ? s.page_start
                            : PAGE_W'(s.page_ptr + 1'b1);
                end
                MODE_VERT:
                begin
                    next_s.page_ptr = page_at_end ? s.page_start
                        : PAGE_W'(s.page_ptr + 1'b1);
                    if (page_at_end)
                        next_s.col_ptr = col_at_end ? s.col_start
                            : COL_W'(s.col_ptr + 1'b1);
                end
                default:
                    next_s = s;
            endcase
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            s <= RST;
        else if (ce_i)
            s <= next_s;
    end

    assign col_ptr_o = s.col_ptr;
    assign page_ptr_o = s.page_ptr;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    sequence s_step(logic [1:0] m);
        ce_i && advance_i && mode_i == m;
    endsequence
    sequence s_both_end;
        col_at_end && page_at_end;
    endsequence

    a_page_col_wrap: assert property (
        s_step(MODE_PAGE) and col_at_end |=>
            col_ptr_o == $past(s.col_start) && $stable(page_ptr_o))
        else $error("page mode column wrap wrong");
    a_horiz_line_end: assert property (
        s_step(MODE_HORIZ) and (col_at_end && !page_at_end) |=>
            col_ptr_o == $past(s.col_start)
            && page_ptr_o == PAGE_W'($past(s.page_ptr) + 1'b1))
        else $error("horizontal wrap wrong");
    a_vert_col_end: assert property (
        s_step(MODE_VERT) and (page_at_end && !col_at_end) |=>
            page_ptr_o == $past(s.page_start)
            && col_ptr_o == COL_W'($past(s.col_ptr) + 1'b1))
        else $error("vertical wrap wrong");
    a_full_wrap: assert property (
        ce_i && advance_i && mode_i != MODE_PAGE ##0 s_both_end |=>
            col_ptr_o == $past(s.col_start)
            && page_ptr_o == $past(s.page_start))
        else $error("end of window wrap wrong");
    a_range_load: assert property (
        ce_i && set_col_start_i |=>
            col_ptr_o == $past(arg_i[COL_W-1:0]))
        else $error("column pointer not loaded");
endmodule : disp_addr_ptr

// ==== disp_cmd_core.sv ====
// Command interpreter, display memory and read path of the controller
`timescale 1ns/1ps
`include "disp_cmd_map.svh"
module disp_cmd_core #(
    parameter int COLS = 128,
    parameter int PAGES = 8,
    parameter int COL_W = $clog2(COLS),
    parameter int PAGE_W = $clog2(PAGES)
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Host transfers, one byte per valid cycle
    input wire logic xfer_valid_i,
    input wire logic xfer_dc_i,
    input wire logic xfer_read_i,
    input wire logic [7:0] xfer_data_i,
    input wire logic serial_mode_i,
    // Read answer
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    // Timing settings
    output logic [3:0] clock_divide_o,
    output logic [3:0] osc_freq_o,
    output logic [3:0] precharge1_o,
    output logic [3:0] precharge2_o,
    output logic [2:0] common_deselect_level_o,
    output logic display_off_o,
    // Addressing
    output disp_cmd_pkg::addr_mode_t addr_mode_o,
    output logic [COL_W-1:0] col_ptr_o,
    output logic [PAGE_W-1:0] page_ptr_o
);
    import disp_cmd_pkg::*;

    localparam int DEPTH = COLS * PAGES;
    localparam int IDX_W = COL_W + PAGE_W;

    typedef struct packed {
        cmd_state_t state;
        logic [3:0] divide;
        logic [3:0] osc;
        logic [3:0] ph1;
        logic [3:0] ph2;
        logic [2:0] desel;
        logic off;
        addr_mode_t mode;
        logic [7:0] rd_latch;
        logic rd_valid;
        logic [7:0] rd_data;
        logic [DEPTH-1:0][7:0] graphic_display_memory;
    } core_state_t;

    localparam core_state_t RST = '{
        state: ST_IDLE,
        divide: `RST_DIVIDE,
        osc: `RST_OSC,
        ph1: `RST_PHASE,
        ph2: `RST_PHASE,
        desel: `RST_DESELECT,
        off: 1'b1,
        mode: MODE_PAGE,
        rd_latch: 8'h00,
        rd_valid: 1'b0,
        rd_data: 8'h00,
        graphic_display_memory: '0
    };

    core_state_t s;
    core_state_t next_s;
    logic eff_read;
    logic cmd_wr;
    logic advance;
    logic [IDX_W-1:0] idx;
    logic set_col_start;
    logic set_col_end;
    logic set_page_start;
    logic set_page_end;
    logic set_col_lo;
    logic set_col_hi;
    logic set_page_sel;

    // Serial hosts can only write, so a read request there is a write
    assign eff_read = xfer_read_i && !serial_mode_i;
    assign cmd_wr = xfer_valid_i && !xfer_dc_i && !eff_read;
    assign idx = {page_ptr_o, col_ptr_o};

    // Decoder, memory access and read answer
    always_comb
    begin
        next_s = s;
        next_s.rd_valid = 1'b0;
        advance = 1'b0;
        set_col_start = 1'b0;
        set_col_end = 1'b0;
        set_page_start = 1'b0;
        set_page_end = 1'b0;
        set_col_lo = 1'b0;
        set_col_hi = 1'b0;
        set_page_sel = 1'b0;
        if (xfer_valid_i && eff_read)
        begin
            next_s.rd_valid = 1'b1;
            if (!xfer_dc_i)
            begin
                // Status byte, reserved bits zero
                next_s.rd_data = 8'h00;
                next_s.rd_data[`STATUS_OFF_BIT] = s.off;
            end
            else
            begin
                // Latch pipeline makes the first read a dummy
                next_s.rd_data = s.rd_latch;
                next_s.rd_latch = s.graphic_display_memory[idx];
                advance = 1'b1;
            end
        end
        else if (xfer_valid_i && xfer_dc_i)
        begin
            next_s.graphic_display_memory[idx] = xfer_data_i;
            advance = 1'b1;
        end
        else if (cmd_wr)
        begin
            next_s.state = ST_IDLE;
            unique case (s.state)
                ST_IDLE:
                begin
                    // Unknown codes are ignored here
                    if (xfer_data_i == `CMD_CLOCK)
                        next_s.state = ST_CLOCK;
                    else if (xfer_data_i == `CMD_PRECHARGE)
                        next_s.state = ST_PRECHARGE;
                    else if (xfer_data_i == `CMD_DESELECT)
                        next_s.state = ST_DESELECT;
                    else if (xfer_data_i == `CMD_MODE)
                        next_s.state = ST_MODE;
                    else if (xfer_data_i == `CMD_COL_RANGE)
                        next_s.state = ST_COL_START;
                    else if (xfer_data_i == `CMD_PAGE_RANGE)
                        next_s.state = ST_PAGE_START;
                    else if (xfer_data_i == `CMD_DISPLAY_OFF)
                        next_s.off = 1'b1;
                    else if (xfer_data_i == `CMD_DISPLAY_ON)
                        next_s.off = 1'b0;
                    else if (xfer_data_i[7:3] == `CMD_PAGE_SEL_TOP)
                        set_page_sel = 1'b1;
                    else if (xfer_data_i[7:4] == `CMD_COL_LO_TOP)
                        set_col_lo = 1'b1;
                    else if (xfer_data_i[7:4] == `CMD_COL_HI_TOP)
                        set_col_hi = 1'b1;
                    // The no-operation byte leaves every setting alone
                    else if (xfer_data_i == `CMD_NOP)
                        next_s.state = ST_IDLE;
                end
                ST_CLOCK:
                begin
                    next_s.divide = xfer_data_i[3:0];
                    next_s.osc = xfer_data_i[7:4];
                end
                ST_PRECHARGE:
                begin
                    // A zero phase is invalid and keeps the old value
                    if (xfer_data_i[3:0] != 4'h0)
                        next_s.ph1 = xfer_data_i[3:0];
                    if (xfer_data_i[7:4] != 4'h0)
                        next_s.ph2 = xfer_data_i[7:4];
                end
                ST_DESELECT:
                    next_s.desel = xfer_data_i[`DESEL_LSB +: 3];
                ST_MODE:
                begin
                    // Code 11 is invalid and leaves the mode alone
                    if (xfer_data_i[1:0] != 2'h3)
                        next_s.mode = addr_mode_t'(xfer_data_i[1:0]);
                end
                ST_COL_START:
                begin
                    set_col_start = 1'b1;
                    next_s.state = ST_COL_END;
                end
                ST_COL_END:
                    set_col_end = 1'b1;
                ST_PAGE_START:
                begin
                    set_page_start = 1'b1;
                    next_s.state = ST_PAGE_END;
                end
                ST_PAGE_END:
                    set_page_end = 1'b1;
                default:
                    next_s.state = ST_IDLE;
            endcase
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            s <= RST;
        else if (ce_i)
            s <= next_s;
    end

    // Pointer unit
    disp_addr_ptr #(
        .COL_W(COL_W),
        .PAGE_W(PAGE_W)
    ) u_ptr (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .mode_i(s.mode),
        .advance_i(advance),
        .arg_i(xfer_data_i),
        .set_col_start_i(set_col_start),
        .set_col_end_i(set_col_end),
        .set_page_start_i(set_page_start),
        .set_page_end_i(set_page_end),
        .set_col_lo_i(set_col_lo),
        .set_col_hi_i(set_col_hi),
        .set_page_sel_i(set_page_sel),
        .col_ptr_o(col_ptr_o),
        .page_ptr_o(page_ptr_o)
    );

    // Outputs straight from the state register
    assign rd_valid_o = s.rd_valid;
    assign rd_data_o = s.rd_data;
    assign clock_divide_o = s.divide;
    assign osc_freq_o = s.osc;
    assign precharge1_o = s.ph1;
    assign precharge2_o = s.ph2;
    assign common_deselect_level_o = s.desel;
    assign display_off_o = s.off;
    assign addr_mode_o = s.mode;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    sequence s_cmd_byte(logic [7:0] b);
        ce_i && cmd_wr && s.state == ST_IDLE && xfer_data_i == b;
    endsequence
    sequence s_arg_byte(cmd_state_t st);
        ce_i && cmd_wr && s.state == st;
    endsequence

    a_clock_fields: assert property (
        s_cmd_byte(`CMD_CLOCK) ##1 s_arg_byte(ST_CLOCK) |=>
            clock_divide_o == $past(xfer_data_i[3:0])
            && osc_freq_o == $past(xfer_data_i[7:4]))
        else $error("clock command fields not stored");
    a_phase_zero: assert property (
        s_arg_byte(ST_PRECHARGE) ##0 xfer_data_i[3:0] == 4'h0 |=>
            $stable(precharge1_o))
        else $error("zero phase one accepted");
    a_deselect_store: assert property (
        s_arg_byte(ST_DESELECT) |=>
            common_deselect_level_o == $past(xfer_data_i[6:4]))
        else $error("deselect level not stored");
    a_nop_idle: assert property (
        s_cmd_byte(`CMD_NOP) |=> s.state == ST_IDLE
            && $stable(s.graphic_display_memory) && $stable(s.rd_latch)
            && $stable(rd_data_o) && $stable(display_off_o)
            && $stable({clock_divide_o, osc_freq_o, precharge1_o})
            && $stable({precharge2_o, common_deselect_level_o})
            && $stable(addr_mode_o) && $stable({col_ptr_o, page_ptr_o}))
        else $error("no-operation changed state");
    a_status_bit: assert property (
        ce_i && xfer_valid_i && eff_read && !xfer_dc_i |=>
            rd_valid_o && rd_data_o == {1'b0, $past(s.off), 6'h00}
            && $stable(col_ptr_o) && $stable(page_ptr_o))
        else $error("status read wrong");
    a_serial_no_read: assert property (
        ce_i && xfer_valid_i && serial_mode_i |=> !rd_valid_o)
        else $error("read answered in serial mode");
    a_read_dummy: assert property (
        ce_i && xfer_valid_i && eff_read && xfer_dc_i |=>
            rd_valid_o && rd_data_o == $past(s.rd_latch)
            ##0 s.rd_latch == $past(s.graphic_display_memory[idx]))
        else $error("data read pipeline wrong");
    a_write_store: assert property (
        ce_i && xfer_valid_i && xfer_dc_i && !eff_read |=>
            s.graphic_display_memory[$past(idx)] == $past(xfer_data_i))
        else $error("data byte not stored");

    // Invalid argument values leave the stored setting alone
    a_phase_two_zero: assert property (
        s_arg_byte(ST_PRECHARGE) ##0 xfer_data_i[7:4] == 4'h0 |=>
            $stable(precharge2_o))
        else $error("zero phase two accepted");
    a_mode_invalid: assert property (
        s_arg_byte(ST_MODE) ##0 xfer_data_i[1:0] == 2'h3 |=>
            $stable(addr_mode_o))
        else $error("invalid addressing mode accepted");

    // Single-byte commands with a visible effect
    a_display_off: assert property (
        s_cmd_byte(`CMD_DISPLAY_OFF) |=> display_off_o)
        else $error("display off command not taken");
    a_col_hi_load: assert property (
        ce_i && cmd_wr && s.state == ST_IDLE
            && xfer_data_i[7:4] == `CMD_COL_HI_TOP |=>
            col_ptr_o[COL_W-1:4] == $past(xfer_data_i[COL_W-5:0]))
        else $error("high column nibble not loaded");

    // Writes never produce a read answer
    a_write_quiet: assert property (
        ce_i && xfer_valid_i && !eff_read |=> !rd_valid_o)
        else $error("read answer after a write");
endmodule : disp_cmd_core

// ==== disp_cmd_core_tb.sv ====
// Self-checking bench of the display command block
`timescale 1ns/1ps
module disp_cmd_core_tb;
    import disp_cmd_pkg::*;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic serial_mode_i = 1'b0;
    logic xfer_valid, xfer_dc, xfer_read, rd_valid, display_off;
    logic [7:0] xfer_data, rd_data;
    logic [3:0] clock_divide, osc_freq, precharge1, precharge2;
    logic [2:0] desel, page_ptr;
    logic [6:0] col_ptr;
    addr_mode_t addr_mode;
    int mismatches = 0;
    int n_tests = 0;

    disp_cmd_core i_disp_cmd_core (
        .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .xfer_valid_i(xfer_valid), .xfer_dc_i(xfer_dc),
        .xfer_read_i(xfer_read), .xfer_data_i(xfer_data),
        .serial_mode_i(serial_mode_i), .rd_valid_o(rd_valid),
        .rd_data_o(rd_data), .clock_divide_o(clock_divide),
        .osc_freq_o(osc_freq), .precharge1_o(precharge1),
        .precharge2_o(precharge2), .common_deselect_level_o(desel),
        .display_off_o(display_off), .addr_mode_o(addr_mode),
        .col_ptr_o(col_ptr), .page_ptr_o(page_ptr)
    );

    host_model i_host_model (
        .clock_i(clock_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
        .xfer_valid_o(xfer_valid), .xfer_dc_o(xfer_dc),
        .xfer_read_o(xfer_read), .xfer_data_o(xfer_data)
    );

    // Clock of 100 ns period
    always #50 clock_i = ~clock_i;

    // Compare and count
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // Command bytes taken from the left of b, back to back
    task automatic cmd(input logic [23:0] b, input int n);
        for (int i = 0; i < n; i++)
            i_host_model.put(1'b0, 1'b0, b[23-8*i -: 8]);
        i_host_model.idle();
        #1;
    endtask : cmd

    task automatic wr(input logic [7:0] d);
        i_host_model.put(1'b1, 1'b0, d);
        i_host_model.idle();
        #1;
    endtask : wr

    // Read; mode 0 no answer, 1 answer only, 2 answer and data
    task automatic rd(input logic dc, input logic [7:0] exp, input int mode);
        logic [7:0] b;
        logic v;
        i_host_model.get(dc, b, v);
        check("read valid", {7'h00, v}, {7'h00, mode != 0});
        if (mode == 2)
            check("read data", b, exp);
    endtask : rd

    task automatic ptr(input logic [6:0] c, input logic [2:0] p);
        check("column pointer", {1'b0, col_ptr}, {1'b0, c});
        check("page pointer", {5'h00, page_ptr}, {5'h00, p});
    endtask : ptr

    task automatic sets(input logic [3:0] dv, os, p1, p2,
        input logic [2:0] dl);
        check("divide", {4'h0, clock_divide}, {4'h0, dv});
        check("oscillator", {4'h0, osc_freq}, {4'h0, os});
        check("phase one", {4'h0, precharge1}, {4'h0, p1});
        check("phase two", {4'h0, precharge2}, {4'h0, p2});
        check("deselect", {5'h00, desel}, {5'h00, dl});
    endtask : sets

    task automatic t_reset();
        sets(4'h0, 4'h8, 4'h2, 4'h2, 3'h2);
        check("mode", {6'h00, addr_mode}, 8'h02);
        check("display off", {7'h00, display_off}, 8'h01);
        ptr(7'h00, 3'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_timing();
        cmd(24'hD5A500, 2);
        sets(4'h5, 4'hA, 4'h2, 4'h2, 3'h2);
        cmd(24'hD93000, 2);
        sets(4'h5, 4'hA, 4'h2, 4'h3, 3'h2);
        cmd(24'hD90400, 2);
        sets(4'h5, 4'hA, 4'h4, 4'h3, 3'h2);
        cmd(24'hD9F100, 2);
        sets(4'h5, 4'hA, 4'h1, 4'hF, 3'h2);
        cmd(24'hDB3000, 2);
        sets(4'h5, 4'hA, 4'h1, 4'hF, 3'h3);
        cmd(24'hDB0000, 2);
        cmd(24'hE30000, 1);
        sets(4'h5, 4'hA, 4'h1, 4'hF, 3'h0);
        ptr(7'h00, 3'h0);
        // Clock enable low: bytes are ignored
        @(posedge clock_i);
        ce_i <= 1'b0;
        cmd(24'hD57700, 2);
        sets(4'h5, 4'hA, 4'h1, 4'hF, 3'h0);
        @(posedge clock_i);
        ce_i <= 1'b1;
        $display("test timing done");
    endtask : t_timing

    task automatic t_status();
        cmd(24'hAF0000, 1);
        rd(1'b0, 8'h00, 2);
        cmd(24'hAE0000, 1);
        rd(1'b0, 8'h40, 2);
        ptr(7'h00, 3'h0);
        $display("test status done");
    endtask : t_status

    task automatic t_page();
        cmd(24'h200300, 2);
        check("mode", {6'h00, addr_mode}, 8'h02);
        cmd(24'h217D7F, 3);
        ptr(7'h7D, 3'h0);
        wr(8'h11);
        wr(8'h22);
        ptr(7'h7F, 3'h0);
        wr(8'h33);
        ptr(7'h7D, 3'h0);
        // Page, then low and high column nibbles
        cmd(24'hB20000, 1);
        cmd(24'h030000, 1);
        cmd(24'h100000, 1);
        ptr(7'h03, 3'h2);
        cmd(24'h120000, 1);
        ptr(7'h23, 3'h2);
        $display("test page done");
    endtask : t_page

    task automatic t_horiz();
        int c;
        int p;
        c = 2;
        p = 5;
        cmd(24'h200000, 2);
        check("mode", {6'h00, addr_mode}, 8'h00);
        cmd(24'h210204, 3);
        cmd(24'h220506, 3);
        ptr(7'h02, 3'h5);
        for (int i = 0; i < 7; i++)
        begin
            wr(8'hA0 + 8'(i));
            if (c == 4)
            begin
                c = 2;
                p = (p == 6) ? 5 : p + 1;
            end
            else
                c++;
            ptr(7'(c), 3'(p));
        end
        $display("test horizontal done");
    endtask : t_horiz

    task automatic t_read();
        cmd(24'h210204, 3);
        cmd(24'h220506, 3);
        rd(1'b1, 8'h00, 1);
        rd(1'b0, 8'h40, 2);
        for (int i = 0; i < 6; i++)
            rd(1'b1, (i == 0) ? 8'hA6 : 8'hA0 + 8'(i), 2);
        ptr(7'h03, 3'h5);
        $display("test read done");
    endtask : t_read

    task automatic t_vert();
        int c;
        int p;
        c = 16;
        p = 6;
        cmd(24'h200100, 2);
        check("mode", {6'h00, addr_mode}, 8'h01);
        cmd(24'h211011, 3);
        cmd(24'h220607, 3);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h50 + 8'(i));
            if (p == 7)
            begin
                p = 6;
                c = (c == 17) ? 16 : c + 1;
            end
            else
                p++;
            ptr(7'(c), 3'(p));
        end
        // Serial host: a read is taken as a data write
        @(posedge clock_i);
        serial_mode_i <= 1'b1;
        rd(1'b1, 8'h00, 0);
        ptr(7'h10, 3'h7);
        @(posedge clock_i);
        serial_mode_i <= 1'b0;
        $display("test vertical done");
    endtask : t_vert

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clock_i);
        resetn_i <= 1'b1;
        #1;
        t_reset();
        t_timing();
        t_status();
        t_page();
        t_horiz();
        t_read();
        t_vert();
        final_report();
    end

    // Watchdog, far beyond the about 130 cycles the tests need
    initial
    begin
        #2000000;
        mismatches++;
        $display("watchdog expired");
        final_report();
    end
endmodule : disp_cmd_core_tb

// ==== disp_cmd_map.svh ====
// Command codes, field positions and reset values of the command block
// What this block does
// - Clock command low nibble sets divide ratio
// - Clock command high nibble sets oscillator setting
// - Pre-charge phases from nibbles, zero ignored
// - Deselect level from bits 6 to 4
// - No-operation byte changes nothing at all
// - Status bit 6 shows display off
// - Serial mode offers no read path
// - Each data read advances the pointers as the mode sets
// - Data writes advance; serial always writes
// - Commands and status reads never advance pointers
// - Page mode wraps column, page unchanged
// - Nibble commands load page-mode column start
// - Horizontal mode wraps column, steps page
// - Vertical mode wraps page, steps column
// - Both ends reached outside page mode: back to both starts
// - Column-range command loads range and pointer
// - Mode command selects horizontal, vertical, page
// - Column range resets to 0 and 127
// - Page range resets 0 to 7, loads pointer
`ifndef DISP_CMD_MAP_SVH
`define DISP_CMD_MAP_SVH
`define CMD_MODE 8'h20
`define CMD_COL_RANGE 8'h21
`define CMD_PAGE_RANGE 8'h22
`define CMD_DISPLAY_OFF 8'hAE
`define CMD_DISPLAY_ON 8'hAF
`define CMD_CLOCK 8'hD5
`define CMD_PRECHARGE 8'hD9
`define CMD_DESELECT 8'hDB
`define CMD_NOP 8'hE3
`define CMD_PAGE_SEL_TOP 5'h16
`define CMD_COL_LO_TOP 4'h0
`define CMD_COL_HI_TOP 4'h1
`define DESEL_LSB 4
`define STATUS_OFF_BIT 6
`define RST_DIVIDE 4'h0
`define RST_OSC 4'h8
`define RST_PHASE 4'h2
`define RST_DESELECT 3'h2
`define RST_COL_START 7'h00
`define RST_COL_END 7'h7F
`define RST_PAGE_START 3'h0
`define RST_PAGE_END 3'h7
`endif

// ==== disp_cmd_pkg.sv ====
// Types shared by the display command block
package disp_cmd_pkg;
    typedef enum logic [1:0] {
        MODE_HORIZ = 2'h0,
        MODE_VERT = 2'h1,
        MODE_PAGE = 2'h2
    } addr_mode_t;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_CLOCK,
        ST_PRECHARGE,
        ST_DESELECT,
        ST_MODE,
        ST_COL_START,
        ST_COL_END,
        ST_PAGE_START,
        ST_PAGE_END
    } cmd_state_t;
endpackage : disp_cmd_pkg

// ==== host_model.sv ====
// Host side model that sends command, data and read transfers
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic clock_i,
    // Read answer from the block
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    // Transfer strobes towards the block
    output logic xfer_valid_o,
    output logic xfer_dc_o,
    output logic xfer_read_o,
    output logic [7:0] xfer_data_o
);
    // Idle bus at time zero
    initial
    begin
        xfer_valid_o = 1'b0;
        xfer_dc_o = 1'b0;
        xfer_read_o = 1'b0;
        xfer_data_o = 8'h00;
    end

    // One byte, presented after an edge and taken at the next one
    task automatic put(input logic dc, input logic rd, input logic [7:0] b);
        @(posedge clock_i);
        xfer_valid_o <= 1'b1;
        xfer_dc_o <= dc;
        xfer_read_o <= rd;
        xfer_data_o <= b;
    endtask : put

    // Release: qualifiers and data no longer show the last byte
    task automatic idle();
        @(posedge clock_i);
        xfer_valid_o <= 1'b0;
        xfer_dc_o <= ~xfer_dc_o;
        xfer_read_o <= ~xfer_read_o;
        xfer_data_o <= ~xfer_data_o;
    endtask : idle

    // Read cycle: answer is sampled the cycle after the taking edge
    task automatic get(input logic dc, output logic [7:0] b, output logic v);
        put(dc, 1'b1, 8'h00);
        idle();
        #1;
        v = rd_valid_i;
        b = rd_data_i;
    endtask : get
endmodule : host_model
